// file: core/gpa_pkg.sv
// shared constants for the port pin control and pin interrupt block
package gpa_pkg;
  localparam int ADDR_W = 6; // byte address width
  localparam int DATA_W = 32; // bus data width
  localparam int PIN_W = 8; // pins in the port
  // byte offsets, one aligned word per register
  localparam logic [5:0] OFF_DATA = 6'h00;
  localparam logic [5:0] OFF_DIR = 6'h04;
  localparam logic [5:0] OFF_PULL = 6'h08;
  localparam logic [5:0] OFF_SLEW = 6'h0C;
  localparam logic [5:0] OFF_DRIVE = 6'h10;
  localparam logic [5:0] OFF_ISC = 6'h14;
  localparam logic [5:0] OFF_PSEL = 6'h18;
  localparam logic [5:0] OFF_ESEL = 6'h1C;
  localparam logic [5:0] OFF_EVT = 6'h20;
  localparam logic [5:0] OFF_EVM = 6'h24;
  // interrupt status/control fields
  localparam int FLAG_BIT = 3;
  localparam int ACK_BIT = 2;
  localparam int IE_BIT = 1;
  localparam int MODE_BIT = 0;
  // event status fields
  localparam int EVT_W = 2;
  localparam int EVT_DETECT = 0;
  localparam int EVT_REFUSED = 1;
  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] RST_SLEW = 8'h00;
  localparam logic [1:0] RST_EVT = 2'h0;
  // bus handshake states
  typedef enum logic [0:0] {
    BUS_ANSWER = 1'b0,
    BUS_WAIT = 1'b1
  } gpa_bus_state_e;
endpackage

// file: core/gpa_reg_if.sv
// register access strobes between the bus slave and the register file
`timescale 1ns/10ps
`default_nettype none
interface gpa_reg_if;
  logic rd_stb; // capture read data, fire read side effects
  logic wr_stb; // write takes effect
  logic [5:0] addr; // byte address of the access
  logic [7:0] wdata; // low write byte
  logic be0; // low byte lane enabled
  logic [7:0] rdata; // register file read mux
  modport bus_side (output rd_stb, output wr_stb, output addr, output wdata,
    output be0, input rdata);
  modport reg_side (input rd_stb, input wr_stb, input addr, input wdata,
    input be0, output rdata);
endinterface
`default_nettype wire

// file: core/gpa_bus_slave.sv
// avalon-mm slave handshake with one wait cycle per access
`timescale 1ns/10ps
`default_nettype none
module gpa_bus_slave (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  gpa_reg_if.bus_side rif
);
  gpa_pkg::gpa_bus_state_e st_q; // wait while a request is fresh
  logic req; // any request pending
  assign req = avs_read | avs_write;
  // read data is caught in the wait cycle so that read side effects and
  // capture happen on the same edge and no event slips between them
  assign rif.rd_stb = avs_read & (st_q == gpa_pkg::BUS_WAIT);
  assign rif.wr_stb = avs_write & (st_q == gpa_pkg::BUS_ANSWER);
  assign rif.addr = avs_address;
  assign rif.wdata = avs_writedata[7:0];
  assign rif.be0 = avs_byteenable[0];
  assign avs_waitrequest = st_q;
  // handshake state: wait one cycle, answer one cycle, back to wait
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      st_q <= gpa_pkg::BUS_WAIT;
    else
      case (st_q)
        gpa_pkg::BUS_WAIT: if (req) st_q <= gpa_pkg::BUS_ANSWER;
        gpa_pkg::BUS_ANSWER: st_q <= gpa_pkg::BUS_WAIT;
        default: st_q <= gpa_pkg::BUS_WAIT;
      endcase
  end
  // read data register, upper bits read zero
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      avs_readdata <= 32'h00000000;
    else if (rif.rd_stb)
      avs_readdata <= {24'h000000, rif.rdata};
  end
endmodule
`default_nettype wire

// file: core/gpa_detect.sv
// synchronous edge and level detector for the selected pins
`timescale 1ns/10ps
`default_nettype none
module gpa_detect (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] pin_in,
  input wire logic [7:0] pin_sel,
  input wire logic [7:0] edge_sel,
  input wire logic level_mode,
  output logic detect,
  output logic any_asserted
);
  logic [7:0] act; // pin at its asserted level this cycle
  logic [7:0] act_prev_q; // asserted level seen last cycle
  logic primed_q; // one sample taken since reset
  // polarity 0 asserts low, polarity 1 asserts high
  assign act = ~(pin_in ^ edge_sel);
  assign any_asserted = |(act & pin_sel);
  // edge: deasserted one cycle, asserted the next; level only in mode 1
  assign detect = primed_q & |(pin_sel & act & (~act_prev_q | {8{level_mode}}));
  // previous sample; priming blocks a false edge straight after reset
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      act_prev_q <= 8'hFF;
      primed_q <= 1'b0;
    end
    else
    begin
      act_prev_q <= act;
      primed_q <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// file: core/gpa_port_top.sv
// port pin control registers, pin outputs and pin interrupt logic
//
// The register addresses and register access over Avalon-MM were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module gpa_port_top (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [7:0] pin_in,
  output logic [7:0] pin_out,
  output logic [7:0] pin_oe,
  output logic [7:0] pin_pull_en,
  output logic [7:0] pin_pull_down,
  output logic [7:0] pin_slew_en,
  output logic [7:0] pin_drive_high,
  output logic port_irq_req,
  output logic irq
);
  gpa_reg_if rif ();

  // address match for one register word
  function automatic logic hit(input logic [5:0] a, input logic [5:0] off);
    hit = (a == off);
  endfunction

  // config registers
  logic [7:0] data_q; // latched output data
  logic [7:0] dir_q; // 1 output, 0 input
  logic [7:0] pull_q; // pull enables
  logic [7:0] slew_q; // slew limit enables
  logic [7:0] drive_q; // high drive selects
  logic [7:0] psel_q; // interrupt pin selects
  logic [7:0] esel_q; // polarity selects
  logic ie_q; // request enable
  logic mode_q; // detection mode
  logic flag_q; // interrupt flag
  logic flag_d;
  logic [1:0] evt_q; // sticky event status
  logic [1:0] evt_d;
  logic [1:0] evm_q; // event mask
  logic [1:0] evt_set;

  // decoded strobes
  logic wr_lo; // write with low lane enabled
  logic ack_wr; // acknowledge written as 1
  logic clear_ok; // acknowledge may clear the flag
  logic detect; // detection this cycle
  logic any_act; // some enabled pin asserted
  logic [7:0] rd_mux;

  gpa_bus_slave u_bus (
    .clk(clk),
    .rst_n(rst_n),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .rif(rif.bus_side)
  );

  gpa_detect u_det (
    .clk(clk),
    .rst_n(rst_n),
    .pin_in(pin_in),
    .pin_sel(psel_q),
    .edge_sel(esel_q),
    .level_mode(mode_q),
    .detect(detect),
    .any_asserted(any_act)
  );

  // registers sit in the low byte lane; a write without it changes nothing
  assign wr_lo = rif.wr_stb & rif.be0;
  // the acknowledge bit is a strobe only, never stored
  assign ack_wr = wr_lo & hit(rif.addr, gpa_pkg::OFF_ISC)
    & rif.wdata[gpa_pkg::ACK_BIT];
  // in level mode an asserted enabled pin keeps the flag up
  assign clear_ok = ~mode_q | ~any_act;

  // plain control registers, each loaded by its own word
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      data_q <= gpa_pkg::RST_BYTE;
      dir_q <= gpa_pkg::RST_BYTE;
      pull_q <= gpa_pkg::RST_BYTE;
      slew_q <= gpa_pkg::RST_SLEW;
      drive_q <= gpa_pkg::RST_BYTE;
      psel_q <= gpa_pkg::RST_BYTE;
      esel_q <= gpa_pkg::RST_BYTE;
    end
    else if (wr_lo)
    begin
      // data writes latch all bits, whatever the direction
      if (hit(rif.addr, gpa_pkg::OFF_DATA))
        data_q <= rif.wdata;
      if (hit(rif.addr, gpa_pkg::OFF_DIR))
        dir_q <= rif.wdata;
      if (hit(rif.addr, gpa_pkg::OFF_PULL))
        pull_q <= rif.wdata;
      if (hit(rif.addr, gpa_pkg::OFF_SLEW))
        slew_q <= rif.wdata;
      if (hit(rif.addr, gpa_pkg::OFF_DRIVE))
        drive_q <= rif.wdata;
      if (hit(rif.addr, gpa_pkg::OFF_PSEL))
        psel_q <= rif.wdata;
      if (hit(rif.addr, gpa_pkg::OFF_ESEL))
        esel_q <= rif.wdata;
    end
  end

  // enable and mode bits of the status/control word
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ie_q <= 1'b0;
      mode_q <= 1'b0;
    end
    else if (wr_lo && hit(rif.addr, gpa_pkg::OFF_ISC))
    begin
      ie_q <= rif.wdata[gpa_pkg::IE_BIT];
      mode_q <= rif.wdata[gpa_pkg::MODE_BIT];
    end
  end

  // flag: detection sets and wins over a same-cycle acknowledge;
  // no write data path reaches it
  always_comb
  begin
    flag_d = flag_q;
    if (detect)
      flag_d = 1'b1;
    else if (ack_wr && clear_ok)
      flag_d = 1'b0;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      flag_q <= 1'b0;
    else
      flag_q <= flag_d;
  end

  // events: a detection, and an acknowledge refused by level mode
  assign evt_set[gpa_pkg::EVT_DETECT] = detect;
  assign evt_set[gpa_pkg::EVT_REFUSED] = ack_wr & ~clear_ok & flag_q;

  // sticky status cleared by its read; a new event still lands
  always_comb
  begin
    evt_d = evt_q;
    if (rif.rd_stb && hit(rif.addr, gpa_pkg::OFF_EVT))
      evt_d = gpa_pkg::RST_EVT;
    evt_d = evt_d | evt_set;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      evt_q <= gpa_pkg::RST_EVT;
      evm_q <= gpa_pkg::RST_EVT;
    end
    else
    begin
      evt_q <= evt_d;
      if (wr_lo && hit(rif.addr, gpa_pkg::OFF_EVM))
        evm_q <= rif.wdata[1:0];
    end
  end

  // read mux; unmapped words and reserved bits read zero
  always_comb
  begin
    rd_mux = 8'h00;
    case (rif.addr)
      gpa_pkg::OFF_DATA: rd_mux = (data_q & dir_q) | (pin_in & ~dir_q);
      gpa_pkg::OFF_DIR: rd_mux = dir_q;
      gpa_pkg::OFF_PULL: rd_mux = pull_q;
      gpa_pkg::OFF_SLEW: rd_mux = slew_q;
      gpa_pkg::OFF_DRIVE: rd_mux = drive_q;
      gpa_pkg::OFF_ISC: rd_mux = {4'h0, flag_q, 1'b0, ie_q, mode_q};
      gpa_pkg::OFF_PSEL: rd_mux = psel_q;
      gpa_pkg::OFF_ESEL: rd_mux = esel_q;
      gpa_pkg::OFF_EVT: rd_mux = {6'h00, evt_q};
      gpa_pkg::OFF_EVM: rd_mux = {6'h00, evm_q};
      default: rd_mux = 8'h00;
    endcase
  end
  // the bus slave registers this, so every read costs one wait cycle
  assign rif.rdata = rd_mux;

  // pin outputs, all registered, so they lag the registers by a cycle
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_out <= 8'h00;
      pin_oe <= 8'h00;
      pin_pull_en <= 8'h00;
      pin_pull_down <= 8'h00;
      pin_slew_en <= 8'h00;
      pin_drive_high <= 8'h00;
    end
    else
    begin
      pin_out <= data_q;
      pin_oe <= dir_q;
      pin_pull_en <= pull_q & ~dir_q;
      pin_pull_down <= pull_q & ~dir_q & esel_q & psel_q;
      pin_slew_en <= slew_q & dir_q;
      pin_drive_high <= drive_q & dir_q;
    end
  end

  // interrupt outputs; the flag request is gated by its enable
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      port_irq_req <= 1'b0;
      irq <= 1'b0;
    end
    else
    begin
      port_irq_req <= flag_q & ie_q;
      irq <= |(evt_q & evm_q);
    end
  end

  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_ack_in_level;
    ack_wr && mode_q && any_act;
  endsequence

  sequence s_isc_read;
    rif.rd_stb && hit(rif.addr, gpa_pkg::OFF_ISC);
  endsequence

  property p_ack_reads_zero;
    s_isc_read ##1 !avs_waitrequest |-> !avs_readdata[gpa_pkg::ACK_BIT];
  endproperty

  chk_oe_follow_dir: assert property (##1 pin_oe == $past(dir_q))
    else $error("output enable does not follow direction");

  chk_read_live_pin: assert property (rif.rd_stb && hit(rif.addr, gpa_pkg::OFF_DATA)
    |=> avs_readdata[7:0]
    == (($past(pin_in) & ~$past(dir_q)) | ($past(data_q) & $past(dir_q))))
    else $error("data read mixes pin and latch wrongly");

  chk_pull_off_out: assert property ((pin_pull_en & pin_oe) == 8'h00)
    else $error("pull device on an output pin");

  chk_pull_enable: assert property (##1 pin_pull_en == ($past(pull_q) & ~$past(dir_q)))
    else $error("pull enable wrong");

  chk_pull_down: assert property ((pin_pull_down & ~pin_pull_en) == 8'h00)
    else $error("pull-down without pull enable");

  chk_slew_input: assert property ((pin_slew_en & ~pin_oe) == 8'h00)
    else $error("slew limit on an input pin");

  chk_drive_input: assert property ((pin_drive_high & ~pin_oe) == 8'h00)
    else $error("high drive on an input pin");

  chk_flag_hold: assert property (flag_q && !ack_wr |=> flag_q)
    else $error("flag lost without acknowledge");

  chk_detect_sets: assert property (detect |=> flag_q ##1 (flag_q || $past(ack_wr)))
    else $error("detection did not set the flag");

  chk_ack_zero: assert property (p_ack_reads_zero)
    else $error("acknowledge bit read as one");

  chk_level_keeps: assert property (s_ack_in_level ##0 flag_q |=> flag_q)
    else $error("level mode flag cleared while pin asserted");

  chk_edge_clears: assert property (ack_wr && !mode_q && !detect |=> !flag_q)
    else $error("edge mode acknowledge did not clear");

  chk_req_gate: assert property ((!ie_q) [*2] |-> !port_irq_req)
    else $error("request raised while disabled");

  chk_req_raise: assert property (flag_q && ie_q |=> port_irq_req)
    else $error("request missing while flag and enable set");

  chk_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer not after one wait cycle");

  chk_evt_sticky: assert property (evt_set != 2'h0 |=> (evt_q & $past(evt_set)) == $past(evt_set))
    else $error("event lost");

  // with no pin selected there is never a detection
  chk_unselected_quiet: assert property (psel_q == 8'h00 |-> !detect)
    else $error("detection with no pin selected");

  // a refused acknowledge is recorded for software
  chk_refused_event: assert property (s_ack_in_level ##0 flag_q
    |=> evt_q[gpa_pkg::EVT_REFUSED])
    else $error("refused acknowledge not recorded");

  // pull-down only on pins selected for interrupt with high polarity
  chk_pull_down_sel: assert property (##1
    (pin_pull_down & ~($past(esel_q) & $past(psel_q))) == 8'h00)
    else $error("pull-down on a pin not selected for it");

  // with every event masked the interrupt line stays low
  chk_irq_masked: assert property ((evm_q == 2'h0) [*2] |-> !irq)
    else $error("interrupt raised with all events masked");
endmodule
`default_nettype wire

// file: sim/gpa_pin_model.sv
// far side of the port pins: external drivers, pull devices and floating pins
`timescale 1ns/10ps
`default_nettype none
module gpa_pin_model (
  input wire logic clk,
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] pin_pull_en,
  input wire logic [7:0] pin_pull_down,
  input wire logic [7:0] ext_en,
  input wire logic [7:0] ext_val,
  output logic [7:0] pin_in
);
  // undriven, unpulled pins wander: inverse of last level, so no lucky zero
  logic [7:0] float_q = 8'h00;
  // floating history, one step per cycle
  always_ff @(posedge clk)
  begin
    float_q <= ~pin_in;
  end
  // resolve each pin: device driver first, then the bench, then the pull device
  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      if (pin_oe[i])
        pin_in[i] = pin_out[i];
      else if (ext_en[i])
        pin_in[i] = ext_val[i];
      else if (pin_pull_en[i])
        pin_in[i] = ~pin_pull_down[i]; // pull-up gives 1, pull-down gives 0
      else
        pin_in[i] = float_q[i];
    end
  end
endmodule
`default_nettype wire

// file: sim/tb_port_a_pin_control_irq.sv
// self-checking bench for the port pin control and pin interrupt block
`timescale 1ns/10ps
`default_nettype none
module tb_port_a_pin_control_irq;
  logic clk = 1'b0; // 25 MHz bus clock
  logic rst_n = 1'b0; // async reset, active low
  logic [5:0] avs_address = 6'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [7:0] pin_in, pin_out, pin_oe, pin_pull_en, pin_pull_down;
  logic [7:0] pin_slew_en, pin_drive_high;
  logic port_irq_req, irq;
  logic [7:0] ext_en = 8'h00; // bench drivers on the pins
  logic [7:0] ext_val = 8'h00;
  int n_fail = 0;
  int num_checks = 0;
  logic [31:0] rd_q; // last read data

  gpa_port_top gpa_port_top_inst (
    .clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .pin_pull_en(pin_pull_en), .pin_pull_down(pin_pull_down),
    .pin_slew_en(pin_slew_en), .pin_drive_high(pin_drive_high),
    .port_irq_req(port_irq_req), .irq(irq));

  gpa_pin_model gpa_pin_model_inst (
    .clk(clk), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pull_en(pin_pull_en),
    .pin_pull_down(pin_pull_down), .ext_en(ext_en), .ext_val(ext_val),
    .pin_in(pin_in));

  // free-running clock
  initial
  begin
    forever #20 clk = ~clk;
  end

  // verdict and end of run
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // one compare, reported at once on a mismatch
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // one bus access; holds the request until waitrequest is seen low
  task automatic bus(input logic wr, input logic [5:0] a, input logic [7:0] d);
    int n = 0;
    avs_address <= a;
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= {24'h0, d};
    // look between edges: the value seen is the one the next rising edge samples,
    // so the bench never races the slave's own update at that edge
    @(negedge clk);
    while (avs_waitrequest !== 1'b0 && n < 100)
    begin
      @(negedge clk);
      n++;
    end
    if (n >= 100)
      chk(32'h0, 32'h1); // bus hang counts as a mismatch
    // read data stands through the rising edge that completes the access
    rd_q = avs_readdata;
    @(posedge clk);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk); // an edge passes before the next request
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask

  // read and compare
  task automatic rchk(input logic [5:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(rd_q, {24'h0, e});
  endtask

  // let pin and register effects settle
  task automatic settle;
    repeat (4) @(posedge clk);
  endtask

  // every register but the data word reads zero after reset; an unmapped word reads zero
  task automatic t_reset;
    for (int i = 1; i < 10; i++)
      rchk(6'(i * 4), 8'h00);
    rchk(6'h3C, 8'h00);
    chk({pin_oe, pin_pull_en, pin_slew_en, pin_drive_high}, 32'h0);
    $display("test reset done");
  endtask

  // direction, data readback, pull, slew and drive gating
  task automatic t_pins;
    ext_en <= 8'hFF;
    ext_val <= 8'h3C;
    wr(gpa_pkg::OFF_DATA, 8'hA5);
    wr(gpa_pkg::OFF_DIR, 8'h0F);
    wr(gpa_pkg::OFF_PULL, 8'hFF);
    wr(gpa_pkg::OFF_SLEW, 8'hFF);
    wr(gpa_pkg::OFF_DRIVE, 8'h55);
    wr(gpa_pkg::OFF_ESEL, 8'h30);
    wr(gpa_pkg::OFF_PSEL, 8'h10);
    settle();
    rchk(gpa_pkg::OFF_DATA, 8'h35);
    chk({24'h0, pin_oe}, 32'h0F);
    chk({24'h0, pin_out}, 32'hA5);
    chk({24'h0, pin_pull_en}, 32'hF0);
    chk({24'h0, pin_pull_down}, 32'h10);
    chk({24'h0, pin_slew_en}, 32'h0F);
    chk({24'h0, pin_drive_high}, 32'h05);
    rchk(gpa_pkg::OFF_PULL, 8'hFF);
    ext_val <= 8'hC3;
    settle();
    rchk(gpa_pkg::OFF_DATA, 8'hC5);
    wr(gpa_pkg::OFF_PULL, 8'h00);
    wr(gpa_pkg::OFF_DIR, 8'h00);
    settle();
    chk({pin_oe, pin_pull_en, pin_slew_en, pin_drive_high}, 32'h0);
    $display("test pins done");
  endtask

  // edge flag, write protection, acknowledge, enable gating, event interrupt
  task automatic t_edge;
    ext_val <= 8'hFF;
    wr(gpa_pkg::OFF_ESEL, 8'h00);
    wr(gpa_pkg::OFF_PSEL, 8'h01);
    wr(gpa_pkg::OFF_ISC, 8'h06);
    wr(gpa_pkg::OFF_EVM, 8'h01);
    bus(1'b0, gpa_pkg::OFF_EVT, 8'h00);
    settle();
    rchk(gpa_pkg::OFF_ISC, 8'h02);
    chk({31'h0, irq}, 32'h0);
    ext_val <= 8'hFE;
    settle();
    chk({30'h0, port_irq_req, irq}, 32'h3);
    rchk(gpa_pkg::OFF_ISC, 8'h0A);
    wr(gpa_pkg::OFF_ISC, 8'h08);
    settle();
    rchk(gpa_pkg::OFF_ISC, 8'h08);
    chk({31'h0, port_irq_req}, 32'h0);
    wr(gpa_pkg::OFF_ISC, 8'h06);
    rchk(gpa_pkg::OFF_ISC, 8'h02);
    rchk(gpa_pkg::OFF_EVT, 8'h01);
    settle();
    chk({30'h0, port_irq_req, irq}, 32'h0);
    $display("test edge done");
  endtask

  // level mode keeps the flag while a selected pin stays asserted
  task automatic t_level;
    wr(gpa_pkg::OFF_ISC, 8'h07);
    settle();
    rchk(gpa_pkg::OFF_ISC, 8'h0B);
    wr(gpa_pkg::OFF_ISC, 8'h07);
    rchk(gpa_pkg::OFF_ISC, 8'h0B);
    rchk(gpa_pkg::OFF_EVT, 8'h03);
    ext_val <= 8'hFF;
    settle();
    wr(gpa_pkg::OFF_ISC, 8'h07);
    rchk(gpa_pkg::OFF_ISC, 8'h03);
    wr(gpa_pkg::OFF_ISC, 8'h06);
    $display("test level done");
  endtask

  // rising polarity and pin exclusion; the left-out pins get rising edges
  // of their own, so only the pin select keeps them from the flag
  task automatic t_polarity;
    ext_val <= 8'h00;
    settle();
    wr(gpa_pkg::OFF_ESEL, 8'hFF);
    wr(gpa_pkg::OFF_ISC, 8'h06);
    rchk(gpa_pkg::OFF_ISC, 8'h02);
    ext_val <= 8'hFE;
    settle();
    rchk(gpa_pkg::OFF_ISC, 8'h02);
    ext_val <= 8'hFF;
    settle();
    rchk(gpa_pkg::OFF_ISC, 8'h0A);
    $display("test polarity done");
  endtask

  // watchdog well beyond the expected run
  initial
  begin
    repeat (20000) @(posedge clk);
    n_fail++;
    end_sim();
  end

  // main sequence
  initial
  begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_pins();
    t_edge();
    t_level();
    t_polarity();
    end_sim();
  end
endmodule
`default_nettype wire
